// ### psp_consts.svh
/*
 constants for the processor slave port: field positions, reset values,
 widths. assumes inclusion by bare name from package and modules.
*/
`ifndef PSP_CONSTS_SVH
`define PSP_CONSTS_SVH
`define PSP_DATA_W 8
`define PSP_CTRL_IN_FULL 7
`define PSP_CTRL_OUT_FULL 6
`define PSP_CTRL_OVERRUN 5
`define PSP_CTRL_SELECT 4
`define PSP_BYTE_RST 8'h00
`define PSP_SYNC_STAGES 2
`endif

// ### psp_host_model.sv
/*
 partner model: an outside 8-bit processor that drives the three
 strobes and the data pins of the slave port through two tasks.
 assumes the testbench supplies the clock and calls the tasks.
*/
`timescale 1ns/10ps
module psp_host_model
   import psp_pkg::*;
(
   input wire logic clk_i,
   input wire logic [7:0] dut_data_i,
   input wire logic [7:0] dut_oe_n_i,
   output logic [7:0] bus_o,
   output logic read_strobe_n_o,
   output logic store_strobe_n_o,
   output logic chip_select_n_o
);
   psp_byte_t drv_r = 8'h00;
   logic own_r = 1'b0;

   // control pins are pure inputs of the port, driven only from here
   initial begin
      read_strobe_n_o = 1'b1;
      store_strobe_n_o = 1'b1;
      chip_select_n_o = 1'b1;
   end

   // ========================================================
   // wire level
   // a released line shows the inverse of the last byte, so a latch
   // that samples too late sees a wrong value, not a stale copy
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (!dut_oe_n_i[i]) begin
            bus_o[i] = dut_data_i[i];
         end else begin
            bus_o[i] = own_r ? drv_r[i] : ~drv_r[i];
         end
      end
   end

   // ========================================================
   // accesses
   // write: data stays on the pins well past the strobe rise
   task automatic write_byte(input psp_byte_t d);
      @(posedge clk_i);
      drv_r <= d;
      own_r <= 1'b1;
      chip_select_n_o <= 1'b0;
      store_strobe_n_o <= 1'b0;
      repeat (5) @(posedge clk_i);
      store_strobe_n_o <= 1'b1;
      chip_select_n_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      own_r <= 1'b0;
   endtask

   // read: also reports the enables one cycle after the strobes fall
   task automatic read_byte(output psp_byte_t d, output psp_byte_t oe);
      @(posedge clk_i);
      chip_select_n_o <= 1'b0;
      read_strobe_n_o <= 1'b0;
      @(posedge clk_i);
      #1 oe = dut_oe_n_i;
      repeat (6) @(posedge clk_i);
      d = bus_o;
      read_strobe_n_o <= 1'b1;
      chip_select_n_o <= 1'b1;
      repeat (4) @(posedge clk_i);
   endtask
endmodule

// ### psp_pkg.sv
/*
 types for the processor slave port.
 assumes psp_consts.svh is on the include path.
*/
`include "psp_consts.svh"
package psp_pkg;
   // access phase, gray coded along idle -> write/read
   typedef enum logic [1:0] {
      PSP_IDLE = 2'b00,
      PSP_WRITE = 2'b01,
      PSP_READ = 2'b10
   } psp_state_t;
   typedef logic [`PSP_DATA_W-1:0] psp_byte_t;
endpackage

// ### psp_strobe_if.sv
/*
 interface carrying synchronised strobes from the synchroniser
 to the port core. assumes one clock domain.
*/
`timescale 1ns/10ps
interface psp_strobe_if;
   logic rd_n;
   logic wr_n;
   logic cs_n;
   modport src (output rd_n, output wr_n, output cs_n);
   modport dst (input rd_n, input wr_n, input cs_n);
endinterface

// ### psp_sync.sv
/*
 two-flop synchroniser for the three strobe pins.
 assumes pins are asynchronous to clk_i; idle level is high.
*/
`timescale 1ns/10ps
module psp_sync
   import psp_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic read_strobe_n_i,
   input wire logic store_strobe_n_i,
   input wire logic chip_select_n_i,
   psp_strobe_if.src sync_o
);
   typedef struct packed {
      logic [2:0] meta;
      logic [2:0] stable;
   } psp_sync_st_t;
   psp_sync_st_t st_r;
   psp_sync_st_t st_nxt;
   // ==========================================================
   // synchroniser stages
   // only the second stage is read outside
   always_comb begin
      st_nxt = st_r;
      st_nxt.meta = {chip_select_n_i, store_strobe_n_i, read_strobe_n_i};
      st_nxt.stable = st_r.meta;
   end
   // strobes idle high, so reset to high avoids a fake access
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         st_r <= {3'h7, 3'h7};
      end else begin
         st_r <= st_nxt;
      end
   end
   assign sync_o.rd_n = st_r.stable[0];
   assign sync_o.wr_n = st_r.stable[1];
   assign sync_o.cs_n = st_r.stable[2];
endmodule

// ### psp_top.sv
/*
 processor slave port core: byte latch shared with an outside
 processor through read, store and chip-select strobes.
 assumes the on-chip cpu drives the *_i control ports synchronously
 and that the strobe pins were set as inputs by software.
*/
`timescale 1ns/10ps
`include "psp_consts.svh"
// Functional notes
// - select bit set turns the 8-bit shared port into a slave latch
// - outside accesses are asynchronous, governed only by the strobes
// - in slave mode control pins are read, store and chip-select inputs
// - write spans chip select and store low; ends when either is high
// - write end latches byte, sets port event and input full flags
// - read start drives output byte onto pins, sets output full flag
// - cpu write during a read drives new byte, output full not set
// - read end releases pins to input and sets port event flag
// - slave mode only in microcontroller mode, no external bus
// - write onto unread byte sets overrun flag, cleared by software
// - select bit clear gives ordinary general purpose port
module psp_top
   import psp_pkg::*;
#(
   parameter int DATA_W = `PSP_DATA_W
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic slave_port_select_i,
   input wire logic mcu_mode_i,
   input wire logic [DATA_W-1:0] data_pin_i,
   output logic [DATA_W-1:0] data_pin_o,
   output logic [DATA_W-1:0] data_pin_oe_n_o,
   input wire logic read_strobe_n_i,
   input wire logic store_strobe_n_i,
   input wire logic chip_select_n_i,
   input wire logic [DATA_W-1:0] gpio_dir_in_i,
   input wire logic cpu_wr_i,
   input wire logic [DATA_W-1:0] cpu_wdata_i,
   input wire logic cpu_rd_i,
   output logic [DATA_W-1:0] cpu_rdata_o,
   input wire logic overrun_clr_i,
   input wire logic event_clr_i,
   output logic input_full_flag_o,
   output logic output_full_flag_o,
   output logic input_overrun_flag_o,
   output logic port_event_flag_o,
   output logic slave_active_o
);
   typedef struct packed {
      psp_state_t state;
      logic [DATA_W-1:0] out_latch;
      logic [DATA_W-1:0] in_latch;
      logic [DATA_W-1:0] pin_in;
      logic [DATA_W-1:0] pin_meta;
      logic in_full;
      logic out_full;
      logic overrun;
      logic event_f;
   } psp_st_t;
   psp_st_t st_r;
   psp_st_t st_nxt;
   psp_strobe_if strobes ();
   logic enabled;
   logic wr_on;
   logic rd_on;

   // ==========================================================
   // strobe synchroniser
   psp_sync u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .read_strobe_n_i(read_strobe_n_i),
      .store_strobe_n_i(store_strobe_n_i),
      .chip_select_n_i(chip_select_n_i),
      .sync_o(strobes.src)
   );

   // ==========================================================
   // access detection
   // external bus mode locks the slave port out entirely
   assign enabled = slave_port_select_i & mcu_mode_i;
   assign wr_on = enabled & ~strobes.cs_n & ~strobes.wr_n;
   assign rd_on = enabled & ~strobes.cs_n & ~strobes.rd_n;

   // ==========================================================
   // next state
   always_comb begin
      st_nxt = st_r;
      // pins are asynchronous: two stages before gpio or latch reads them
      // the outside processor must hold data one cycle past the strobe
      st_nxt.pin_meta = data_pin_i;
      st_nxt.pin_in = st_r.pin_meta;
      // cpu side: write sets output full unless a read is ongoing
      if (cpu_wr_i) begin
         st_nxt.out_latch = cpu_wdata_i;
         if (st_r.state != PSP_READ) begin
            st_nxt.out_full = 1'b1;
         end
      end
      if (cpu_rd_i && enabled) begin
         st_nxt.in_full = 1'b0;
      end
      if (overrun_clr_i) begin
         st_nxt.overrun = 1'b0;
      end
      if (event_clr_i) begin
         st_nxt.event_f = 1'b0;
      end
      // outside access sequencing; hardware sets beat cpu clears
      case (st_r.state)
         PSP_IDLE: begin
            if (wr_on) begin
               st_nxt.state = PSP_WRITE;
            end else if (rd_on) begin
               st_nxt.state = PSP_READ;
               st_nxt.out_full = 1'b1;
            end
         end
         PSP_WRITE: begin
            if (!wr_on) begin
               st_nxt.state = PSP_IDLE;
               st_nxt.in_latch = st_r.pin_in;
               st_nxt.in_full = 1'b1;
               st_nxt.event_f = 1'b1;
               if (st_r.in_full) begin
                  st_nxt.overrun = 1'b1;
               end
            end
         end
         PSP_READ: begin
            if (!rd_on) begin
               st_nxt.state = PSP_IDLE;
               st_nxt.event_f = 1'b1;
            end
         end
         default: begin
            st_nxt.state = PSP_IDLE;
         end
      endcase
   end

   // ==========================================================
   // state register
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ==========================================================
   // outputs
   // pins driven only in read phase, or in gpio mode per direction
   always_comb begin
      if (enabled) begin
         data_pin_oe_n_o = (st_r.state == PSP_READ) ? '0 : '1;
      end else begin
         data_pin_oe_n_o = gpio_dir_in_i;
      end
   end
   assign data_pin_o = st_r.out_latch;
   assign cpu_rdata_o = enabled ? st_r.in_latch : st_r.pin_in;
   assign input_full_flag_o = st_r.in_full;
   assign output_full_flag_o = st_r.out_full;
   assign input_overrun_flag_o = st_r.overrun;
   assign port_event_flag_o = st_r.event_f;
   assign slave_active_o = enabled;

   // ==========================================================
   // assertions
   a_write_end_flags: assert property (
      @(posedge clk_i) disable iff (rst_i)
      st_r.state == PSP_WRITE && !wr_on |=> st_r.in_full && st_r.event_f)
      else $error("write end did not set flags");
   a_overrun_set: assert property (
      @(posedge clk_i) disable iff (rst_i)
      st_r.state == PSP_WRITE && !wr_on && st_r.in_full
      |=> st_r.overrun)
      else $error("overrun not flagged");
   a_read_drive: assert property (
      @(posedge clk_i) disable iff (rst_i)
      enabled && st_r.state == PSP_READ |-> data_pin_oe_n_o == '0)
      else $error("read phase not driving pins");
   a_read_obf: assert property (
      @(posedge clk_i) disable iff (rst_i)
      st_r.state == PSP_IDLE && rd_on && !wr_on |=> st_r.out_full)
      else $error("read start did not set output full");
   // out_full is already high from the read start, so the check is
   // that a cpu write inside the read leaves it as it was
   a_read_cpu_wr: assert property (
      @(posedge clk_i) disable iff (rst_i)
      st_r.state == PSP_READ && rd_on && cpu_wr_i
      |=> data_pin_o == $past(cpu_wdata_i)
      && st_r.out_full == $past(st_r.out_full))
      else $error("cpu write in read mishandled");
   a_read_end: assert property (
      @(posedge clk_i) disable iff (rst_i)
      st_r.state == PSP_READ && !rd_on
      |=> st_r.event_f && st_r.state == PSP_IDLE)
      else $error("read end mishandled");
   a_gpio_dir: assert property (
      @(posedge clk_i) disable iff (rst_i)
      !enabled |-> data_pin_oe_n_o == gpio_dir_in_i)
      else $error("gpio direction not followed");
   a_mode_gate: assert property (
      @(posedge clk_i) disable iff (rst_i)
      !mcu_mode_i && st_r.state == PSP_IDLE |=> st_r.state == PSP_IDLE)
      else $error("slave access outside mcu mode");
   a_sync_delay: assert property (
      @(posedge clk_i) disable iff (rst_i)
      strobes.wr_n == $past(store_strobe_n_i, 2))
      else $error("strobe sync depth wrong");
   a_cpu_rd_clr: assert property (
      @(posedge clk_i) disable iff (rst_i)
      enabled && cpu_rd_i && !(st_r.state == PSP_WRITE && !wr_on)
      |=> !st_r.in_full)
      else $error("cpu read did not clear input full");
   a_cpu_wr_obf: assert property (
      @(posedge clk_i) disable iff (rst_i)
      cpu_wr_i && st_r.state != PSP_READ
      |=> st_r.out_full && st_r.out_latch == $past(cpu_wdata_i))
      else $error("cpu write did not set output full");
   c_write: cover property (@(posedge clk_i) disable iff (rst_i)
      st_r.state == PSP_WRITE ##1 st_r.state == PSP_IDLE);
   c_read: cover property (@(posedge clk_i) disable iff (rst_i)
      st_r.state == PSP_READ ##1 st_r.state == PSP_IDLE);
   c_overrun: cover property (@(posedge clk_i) disable iff (rst_i)
      $rose(st_r.overrun));
   c_read_cpu_wr: cover property (@(posedge clk_i) disable iff (rst_i)
      st_r.state == PSP_READ && cpu_wr_i);
   c_read_empty: cover property (@(posedge clk_i) disable iff (rst_i)
      st_r.state == PSP_IDLE && rd_on && !st_r.out_full);
endmodule

// ### tb_top.sv
/*
 self-checking bench for the slave port: cpu-side pulses and outside
 processor accesses through the partner model, flags compared.
 assumes a 10 MHz clock and no other driver of the pins.
*/
`timescale 1ns/10ps
module tb_top
   import psp_pkg::*;
;
   logic clk_i, rst_i, sel_i, mcu_i, cpu_wr_i, cpu_rd_i, ov_clr_i, ev_clr_i;
   psp_byte_t gdir_i, cpu_wdata_i, bus, pin_o, oe_n, rdata, rd_v, oe_v;
   logic rd_n, wr_n, cs_n, ifl, ofl, ovr, evt, act;
   int err_total = 0;
   int n_tests = 0;
   // flags packed as in=8 out=4 overrun=2 event=1
   wire logic [7:0] flags = {4'h0, ifl, ofl, ovr, evt};

   psp_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .slave_port_select_i(sel_i),
      .mcu_mode_i(mcu_i), .data_pin_i(bus), .data_pin_o(pin_o),
      .data_pin_oe_n_o(oe_n), .read_strobe_n_i(rd_n),
      .store_strobe_n_i(wr_n), .chip_select_n_i(cs_n),
      .gpio_dir_in_i(gdir_i), .cpu_wr_i(cpu_wr_i), .cpu_wdata_i(cpu_wdata_i),
      .cpu_rd_i(cpu_rd_i), .cpu_rdata_o(rdata), .overrun_clr_i(ov_clr_i),
      .event_clr_i(ev_clr_i), .input_full_flag_o(ifl),
      .output_full_flag_o(ofl), .input_overrun_flag_o(ovr),
      .port_event_flag_o(evt), .slave_active_o(act));
   psp_host_model mdl_u (.clk_i(clk_i), .dut_data_i(pin_o),
      .dut_oe_n_i(oe_n), .bus_o(bus), .read_strobe_n_o(rd_n),
      .store_strobe_n_o(wr_n), .chip_select_n_o(cs_n));

   // ========================================================
   // helpers
   task automatic check(string n, psp_byte_t seen, psp_byte_t exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task automatic test_done;
      if (err_total == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic settle;
      repeat (2) @(posedge clk_i);
      #1;
   endtask
   // one-cycle pulse on {cpu_rd_i, ov_clr_i, ev_clr_i}
   task automatic pulse(input logic [2:0] m);
      @(posedge clk_i);
      {cpu_rd_i, ov_clr_i, ev_clr_i} <= m;
      @(posedge clk_i);
      {cpu_rd_i, ov_clr_i, ev_clr_i} <= 3'h0;
      settle();
   endtask
   task automatic cpu_write(input psp_byte_t d);
      @(posedge clk_i);
      cpu_wdata_i <= d;
      cpu_wr_i <= 1'b1;
      @(posedge clk_i);
      cpu_wr_i <= 1'b0;
   endtask

   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end
   // watchdog: a hang counts as a mismatch
   initial begin
      repeat (5000) @(posedge clk_i);
      err_total++;
      test_done();
   end

   // ========================================================
   // main sequence
   initial begin
      {rst_i, sel_i, mcu_i} = 3'b101;
      {cpu_wr_i, cpu_rd_i, ov_clr_i, ev_clr_i} = 4'h0;
      gdir_i = 8'hF0;
      cpu_wdata_i = 8'h00;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      settle();
      check("flags", flags, 8'h00);
      check("pins", pin_o, 8'h00);
      check("oe_gpio", oe_n, 8'hF0);
      mdl_u.write_byte(8'h3C);
      settle();
      check("gpio_write", flags, 8'h00);
      check("gpio_rd", rdata, 8'hC0);
      @(posedge clk_i);
      sel_i <= 1'b1;
      mcu_i <= 1'b0;
      mdl_u.write_byte(8'h3C);
      settle();
      check("act", {7'h00, act}, 8'h00);
      check("no_mcu", flags, 8'h00);
      @(posedge clk_i);
      mcu_i <= 1'b1;
      settle();
      check("oe_idle", oe_n, 8'hFF);
      cpu_write(8'hAA);
      settle();
      check("cpu_wr", flags, 8'h04);
      mdl_u.read_byte(rd_v, oe_v);
      #1;
      check("rd_data", rd_v, 8'hAA);
      check("rd_sync", oe_v, 8'hFF);
      check("rd_end", flags, 8'h05);
      check("oe_rel", oe_n, 8'hFF);
      pulse(3'h1);
      check("ev_clr", flags, 8'h04);
      fork
         mdl_u.read_byte(rd_v, oe_v);
         begin
            repeat (3) @(posedge clk_i);
            cpu_write(8'h55);
         end
      join
      #1;
      check("rd_new", rd_v, 8'h55);
      pulse(3'h1);
      mdl_u.write_byte(8'h3C);
      #1;
      check("wr_end", flags, 8'h0D);
      check("wr_byte", rdata, 8'h3C);
      mdl_u.write_byte(8'hC3);
      #1;
      check("overrun", flags, 8'h0F);
      check("wr_byte2", rdata, 8'hC3);
      pulse(3'h4);
      check("cpu_rd", flags, 8'h07);
      pulse(3'h2);
      check("ov_clr", flags, 8'h05);
      // second reset in mid-run, then a read from an empty output buffer
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      settle();
      check("rst_flags", flags, 8'h00);
      check("rst_pins", pin_o, 8'h00);
      mdl_u.read_byte(rd_v, oe_v);
      #1;
      check("rd_empty", rd_v, 8'h00);
      check("rd_obf", flags, 8'h05);
      test_done();
   end
endmodule
